// ==== include/tws_pkg.sv ====
// shared constants and types for the two-wire register port
package tws_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 1000;
  // quarter of an scl period, a least time so rounded up
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  // target address: six fixed upper bits, low bit from the select input
  localparam logic [5:0] TGT_ADDR_HI = 6'h26;
  // byte framing
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // master sequence steps
  localparam logic [2:0] STEP_DEV_WR = 3'h1;
  localparam logic [2:0] STEP_REG = 3'h2;
  localparam logic [2:0] STEP_RESTART = 3'h3;
  localparam logic [2:0] STEP_DEV_RD = 3'h4;
  localparam logic [2:0] STEP_RX = 3'h5;
  localparam logic [2:0] STEP_W_STOP = 3'h4;
  localparam logic [2:0] STEP_R_STOP = 3'h6;
  // quarter phases of one bit slot
  localparam logic [1:0] Q_SETUP = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;
  typedef enum logic [2:0] {K_START, K_TX, K_RX, K_STOP, K_END} twsKind_t;
endpackage

// ==== include/tws_if.sv ====
// open-drain two-wire bus joining the master end and the target end
`timescale 1ns/100ps
interface tws_if;
  logic mSclOut;
  logic mSclOe;
  logic mSdaOut;
  logic mSdaOe;
  logic tSdaOut;
  logic tSdaOe;
  logic scl;
  logic sda;
  // pull-ups: a line is low only while some end drives a low
  assign scl = ~(mSclOe & ~mSclOut);
  assign sda = ~((mSdaOe & ~mSdaOut) | (tSdaOe & ~tSdaOut));
  modport master (input scl, input sda, output mSclOut, output mSclOe,
                  output mSdaOut, output mSdaOe);
  modport target (input scl, input sda, output tSdaOut, output tSdaOe);
endinterface

// ==== hdl/tws_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module tws_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // pins and result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } twsSyncReg_t;
  twsSyncReg_t st_r;
  twsSyncReg_t st_nxt;
  ////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end
  // idle lines are high, so reset high avoids a false start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.s2;
endmodule

// ==== hdl/tws_target.sv ====
// two-wire target end: register port slave with auto-increment
`timescale 1ns/100ps
module tws_target (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // bus
  tws_if.target bus,
  // address select strap
  input wire logic addrSel,
  // register file access
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  input wire logic [7:0] regRdData
);
  typedef enum logic [2:0] {
    T_IDLE,
    T_RECV,
    T_ACK,
    T_SEND,
    T_MACK,
    T_IGNORE
  } twsTgtState_t;

  typedef enum logic [1:0] {
    PH_DEV,
    PH_REG,
    PH_DATA
  } twsPhase_t;

  typedef struct packed {
    twsTgtState_t state;
    twsPhase_t phase;
    logic rdMode;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sclP;
    logic sdaP;
    logic sdaOe;
    logic wrEn;
    logic [7:0] wrData;
  } twsTgtReg_t;

  twsTgtReg_t st_r;
  twsTgtReg_t st_nxt;
  logic sclS;
  logic sdaS;
  logic selS;
  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;

  function automatic logic [6:0] ownAddr(input logic sel);
    return {tws_pkg::TGT_ADDR_HI, sel};
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin sampling: scl, sda and strap all come from outside
  tws_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din({bus.scl, bus.sda, addrSel}),
    .dout({sclS, sdaS, selS})
  );

  ////////////////////////////////////////////////////////////////
  // line events, seen on the synchronised copies only
  assign sclRise = sclS & ~st_r.sclP;
  assign sclFall = ~sclS & st_r.sclP;
  // sda moving under a high scl is a condition, never data
  assign startC = sclS & st_r.sclP & st_r.sdaP & ~sdaS;
  assign stopC = sclS & st_r.sclP & ~st_r.sdaP & sdaS;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrEn = 1'b0;
    st_nxt.sclP = sclS;
    st_nxt.sdaP = sdaS;
    if (stopC) begin
      st_nxt.state = T_IDLE;
      st_nxt.sdaOe = 1'b0;
    end else if (startC) begin
      // also taken mid-transfer: a repeated start
      st_nxt.state = T_RECV;
      st_nxt.phase = PH_DEV;
      st_nxt.bitCnt = 4'h0;
      st_nxt.sdaOe = 1'b0;
    end else begin
      unique case (st_r.state)
        T_IDLE, T_IGNORE: begin
          // bus watched only for start or stop
          st_nxt.sdaOe = 1'b0;
        end
        T_RECV: begin
          if (sclRise && st_r.bitCnt != tws_pkg::ACK_BIT) begin
            st_nxt.shift = {st_r.shift[6:0], sdaS};
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
          end else if (sclFall && st_r.bitCnt == tws_pkg::ACK_BIT) begin
            st_nxt.bitCnt = 4'h0;
            st_nxt.state = T_ACK;
            st_nxt.sdaOe = 1'b1;
            unique case (st_r.phase)
              PH_DEV: begin
                if (st_r.shift[7:1] == ownAddr(selS)) begin
                  st_nxt.rdMode = st_r.shift[0];
                end else begin
                  // no ack, base address left alone
                  st_nxt.state = T_IGNORE;
                  st_nxt.sdaOe = 1'b0;
                end
              end
              PH_REG: begin
                st_nxt.ptr = st_r.shift;
              end
              default: begin
                st_nxt.wrEn = 1'b1;
                st_nxt.wrData = st_r.shift;
              end
            endcase
          end
        end
        T_ACK: begin
          if (sclFall) begin
            st_nxt.sdaOe = 1'b0;
            if (st_r.rdMode) begin
              // first bit must be on the line before the next rise
              st_nxt.shift = regRdData;
              st_nxt.sdaOe = ~regRdData[7];
              st_nxt.bitCnt = 4'h0;
              st_nxt.state = T_SEND;
            end else begin
              st_nxt.state = T_RECV;
              unique case (st_r.phase)
                PH_DEV: begin
                  st_nxt.phase = PH_REG;
                end
                PH_REG: begin
                  st_nxt.phase = PH_DATA;
                end
                default: begin
                  // moved after the write strobe so the strobe sees the old address
                  st_nxt.ptr = st_r.ptr + 8'h01;
                end
              endcase
            end
          end
        end
        T_SEND: begin
          if (sclFall) begin
            if (st_r.bitCnt == tws_pkg::LAST_TX_BIT) begin
              st_nxt.sdaOe = 1'b0;
              st_nxt.bitCnt = 4'h0;
              st_nxt.state = T_MACK;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.sdaOe = ~st_r.shift[6];
              st_nxt.bitCnt = st_r.bitCnt + 4'h1;
            end
          end
        end
        T_MACK: begin
          if (sclRise) begin
            st_nxt.ptr = st_r.ptr + 8'h01;
            if (sdaS) begin
              // end of data: released, waiting for stop
              st_nxt.state = T_IGNORE;
            end else begin
              st_nxt.state = T_ACK;
            end
          end
        end
        default: begin
          st_nxt.state = T_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= '0;
      // idle lines are high: no false edge once reset lets go
      st_r.sclP <= 1'b1;
      st_r.sdaP <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // open drain: the output level is always low, only the enable moves
  assign bus.tSdaOut = 1'b0;
  assign bus.tSdaOe = st_r.sdaOe;
  assign regAddr = st_r.ptr;
  assign regWrData = st_r.wrData;
  assign regWrEn = st_r.wrEn;
endmodule

// ==== hdl/tws_master.sv ====
// two-wire master end: single register write or read per command
`timescale 1ns/100ps
module tws_master (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // bus
  tws_if.master bus,
  // command
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [6:0] cmdDev,
  input wire logic [7:0] cmdReg,
  input wire logic [7:0] cmdData,
  output logic cmdReady,
  // result
  output logic done,
  output logic nack,
  output logic [7:0] rdData
);
  typedef enum logic {M_IDLE, M_RUN} twsMstState_t;
  typedef struct packed {
    twsMstState_t state;
    logic rd;
    logic [6:0] dev;
    logic [7:0] rg;
    logic [7:0] dat;
    logic [2:0] step;
    logic [1:0] q;
    logic [7:0] tick;
    logic [3:0] bitCnt;
    logic [7:0] sh;
    logic [7:0] rdData;
    logic nack;
    logic done;
    logic ready;
    logic sclOe;
    logic sdaOe;
  } twsMstReg_t;
  twsMstReg_t st_r;
  twsMstReg_t st_nxt;
  logic sdaS;
  logic qTick;
  tws_pkg::twsKind_t kind;
  logic [7:0] txB;

  // write: start, dev+w, reg, data, stop; read restarts after reg
  function automatic tws_pkg::twsKind_t stepKind(input logic rd, input logic [2:0] s);
    if (s == 3'h0 || (rd && s == tws_pkg::STEP_RESTART)) begin
      return tws_pkg::K_START;
    end else if (!rd && s < tws_pkg::STEP_W_STOP) begin
      return tws_pkg::K_TX;
    end else if (!rd && s == tws_pkg::STEP_W_STOP) begin
      return tws_pkg::K_STOP;
    end else if (rd && s == tws_pkg::STEP_RX) begin
      return tws_pkg::K_RX;
    end else if (rd && s < tws_pkg::STEP_RX) begin
      return tws_pkg::K_TX;
    end else if (rd && s == tws_pkg::STEP_R_STOP) begin
      return tws_pkg::K_STOP;
    end
    return tws_pkg::K_END;
  endfunction

  ////////////////////////////////////////////////////////////////
  tws_sync #(
    .W(1)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din(bus.sda),
    .dout(sdaS)
  );

  ////////////////////////////////////////////////////////////////
  assign qTick = (st_r.tick == tws_pkg::QTR_LAST);
  assign kind = stepKind(st_r.rd, st_r.step);
  always_comb begin
    unique case (st_r.step)
      tws_pkg::STEP_DEV_WR: txB = {st_r.dev, 1'b0};
      tws_pkg::STEP_REG: txB = st_r.rg;
      tws_pkg::STEP_DEV_RD: txB = {st_r.dev, 1'b1};
      default: txB = st_r.dat;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (st_r.state == M_IDLE) begin
      st_nxt.tick = 8'h00;
      st_nxt.q = tws_pkg::Q_SETUP;
      if (cmdValid && st_r.ready) begin
        st_nxt.state = M_RUN;
        st_nxt.rd = cmdRead;
        st_nxt.dev = cmdDev;
        st_nxt.rg = cmdReg;
        st_nxt.dat = cmdData;
        st_nxt.step = 3'h0;
        st_nxt.bitCnt = 4'h0;
        st_nxt.nack = 1'b0;
      end
    end else begin
      st_nxt.tick = qTick ? 8'h00 : st_r.tick + 8'h01;
      if (qTick) begin
        st_nxt.q = st_r.q + 2'h1;
        unique case (kind)
          tws_pkg::K_START: begin
            unique case (st_r.q)
              tws_pkg::Q_SETUP: st_nxt.sdaOe = 1'b0;
              tws_pkg::Q_RISE: st_nxt.sclOe = 1'b0;
              tws_pkg::Q_SAMPLE: st_nxt.sdaOe = 1'b1;
              default: begin
                st_nxt.sclOe = 1'b1;
                st_nxt.step = st_r.step + 3'h1;
              end
            endcase
          end
          tws_pkg::K_STOP: begin
            unique case (st_r.q)
              tws_pkg::Q_SETUP: st_nxt.sdaOe = 1'b1;
              tws_pkg::Q_RISE: st_nxt.sclOe = 1'b0;
              tws_pkg::Q_SAMPLE: st_nxt.sdaOe = 1'b0;
              default: st_nxt.step = st_r.step + 3'h1;
            endcase
          end
          tws_pkg::K_TX, tws_pkg::K_RX: begin
            unique case (st_r.q)
              tws_pkg::Q_SETUP: begin
                // data moves only while scl is held low
                st_nxt.sdaOe = 1'b0;
                if (kind == tws_pkg::K_TX && st_r.bitCnt != tws_pkg::ACK_BIT) begin
                  st_nxt.sh = (st_r.bitCnt == 4'h0) ? txB : st_r.sh;
                  st_nxt.sdaOe = ~st_nxt.sh[7];
                end
              end
              tws_pkg::Q_RISE: st_nxt.sclOe = 1'b0;
              tws_pkg::Q_SAMPLE: begin
                if (kind == tws_pkg::K_TX && st_r.bitCnt == tws_pkg::ACK_BIT) begin
                  st_nxt.nack = sdaS;
                end else if (kind == tws_pkg::K_RX && st_r.bitCnt != tws_pkg::ACK_BIT) begin
                  st_nxt.sh = {st_r.sh[6:0], sdaS};
                end
              end
              default: begin
                st_nxt.sclOe = 1'b1;
                if (st_r.bitCnt == tws_pkg::ACK_BIT) begin
                  st_nxt.bitCnt = 4'h0;
                  st_nxt.step = st_r.step + 3'h1;
                  if (kind == tws_pkg::K_RX) begin
                    // ninth slot left released: nack ends the read
                    st_nxt.rdData = st_r.sh;
                  end else if (st_r.nack) begin
                    st_nxt.step = st_r.rd ? tws_pkg::STEP_R_STOP : tws_pkg::STEP_W_STOP;
                  end
                end else begin
                  if (kind == tws_pkg::K_TX) begin
                    st_nxt.sh = {st_r.sh[6:0], 1'b0};
                  end
                  st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                end
              end
            endcase
          end
          default: begin
            st_nxt.done = 1'b1;
            st_nxt.state = M_IDLE;
            st_nxt.sclOe = 1'b0;
            st_nxt.sdaOe = 1'b0;
          end
        endcase
      end
    end
    st_nxt.ready = (st_nxt.state == M_IDLE);
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // lines are only ever pulled low
  assign bus.mSclOut = 1'b0;
  assign bus.mSdaOut = 1'b0;
  assign bus.mSclOe = st_r.sclOe;
  assign bus.mSdaOe = st_r.sdaOe;
  assign cmdReady = st_r.ready;
  assign done = st_r.done;
  assign nack = st_r.nack;
  assign rdData = st_r.rdData;
endmodule

// ==== testbench/tws_properties.sv ====
// concurrent checks on the bus that joins the design master and target
`timescale 1ns/100ps
module tws_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // master end
  input wire logic mSclOut,
  input wire logic mSclOe,
  input wire logic mSdaOut,
  input wire logic mSdaOe,
  // target end
  input wire logic tSdaOut,
  input wire logic tSdaOe,
  // resolved lines
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  tgt_open_drain_a: assert property (tSdaOe |-> !tSdaOut && !sda)
    else $error("target drives sda high");
  mst_open_drain_a: assert property ((mSdaOe |-> !mSdaOut && !sda) and (mSclOe |-> !scl))
    else $error("master drives a line high");
  reset_release_a: assert property ($rose(rst_b) |-> !tSdaOe && !mSdaOe && !mSclOe)
    else $error("lines not released out of reset");
  // target may only move sda well inside the low phase
  tgt_change_low_a: assert property ($changed(tSdaOe) |-> !scl && !$past(scl, 2))
    else $error("target moved sda near scl high");
  ack_hold_a: assert property ($rose(tSdaOe) |=> tSdaOe[*8])
    else $error("target low drive too short");
  start_quiet_a: assert property (scl && $fell(sda) |=> !tSdaOe[*8])
    else $error("target drives right after start");
  stop_quiet_a: assert property (scl && $rose(sda) |=> !tSdaOe[*8])
    else $error("target drives right after stop");
  scl_high_min_a: assert property ($rose(scl) |=> scl[*8])
    else $error("scl high phase too short");
endmodule

// ==== testbench/tb_two_wire_register_slave_port.sv ====
// self-checking bench: design master and target, plus a bench master on a second bus
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_two_wire_register_slave_port;
  logic ref_clk, rst_b, cmdValid, cmdRead, cmdReady, done, nack;
  logic [6:0] cmdDev;
  logic [7:0] cmdReg, cmdData, rdData, addr0, addr1, wrData0, wrData1;
  logic addrSel0, addrSel1, wrEn0, wrEn1;
  logic [7:0] regs0 [256];
  logic [7:0] regs1 [256];
  logic [6:0] dev0, dev1;
  int miscompares, cmpCount, cycles;
  tws_if bus0();
  tws_if bus1();
  ////////////////////////////////////////////////////////////////////////////
  tws_master tws_master_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus0),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdDev(cmdDev), .cmdReg(cmdReg),
    .cmdData(cmdData), .cmdReady(cmdReady), .done(done), .nack(nack), .rdData(rdData));
  tws_target tws_target_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus0),
    .addrSel(addrSel0), .regAddr(addr0), .regWrData(wrData0), .regWrEn(wrEn0),
    .regRdData(regs0[addr0]));
  // second target, driven by the bench so bursts and faults can be made
  tws_target tws_target_b_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus1),
    .addrSel(addrSel1), .regAddr(addr1), .regWrData(wrData1), .regWrEn(wrEn1),
    .regRdData(regs1[addr1]));
  tws_properties tws_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .mSclOut(bus0.mSclOut), .mSclOe(bus0.mSclOe), .mSdaOut(bus0.mSdaOut),
    .mSdaOe(bus0.mSdaOe), .tSdaOut(bus0.tSdaOut), .tSdaOe(bus0.tSdaOe),
    .scl(bus0.scl), .sda(bus0.sda));
  ////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (wrEn0) regs0[addr0] <= wrData0;
    if (wrEn1) regs1[addr1] <= wrData1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task mCmd(input logic rd, input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] dat);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 200) begin
      @(posedge ref_clk); #1; n++;
    end
    cmdValid = 1'b1; cmdRead = rd; cmdDev = dev; cmdReg = rg; cmdData = dat;
    @(posedge ref_clk); #1;
    cmdValid = 1'b0;
    `CHK("busy", 1'b0, cmdReady);
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge ref_clk); #1; n++;
    end
    `CHK("done seen", 1'b1, done);
    `CHK("ready back", 1'b1, cmdReady);
  endtask
  // bench master: a quarter is 4 cycles, so scl runs at 160 ns inside frames
  task quarter;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task bBit(input logic b, output logic s);
    bus1.mSdaOe = ~b; quarter(); bus1.mSclOe = 1'b0; quarter();
    s = bus1.sda; quarter(); bus1.mSclOe = 1'b1; quarter();
  endtask
  task bStart;
    bus1.mSdaOe = 1'b0; quarter(); bus1.mSclOe = 1'b0; quarter();
    bus1.mSdaOe = 1'b1; quarter(); bus1.mSclOe = 1'b1; quarter();
  endtask
  task bStop;
    bus1.mSdaOe = 1'b1; quarter(); bus1.mSclOe = 1'b0; quarter(); bus1.mSdaOe = 1'b0; quarter();
  endtask
  task bByte(input logic [7:0] d, output logic ackd);
    logic s;
    for (int i = 7; i >= 0; i--) bBit(d[i], s);
    bBit(1'b1, s);
    ackd = ~s;
  endtask
  task bRead(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bBit(1'b1, s);
      d[i] = s;
    end
    bBit(~ackIt, s);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task testMasterPair;
    mCmd(1'b0, {tws_pkg::TGT_ADDR_HI, 1'b0}, 8'h5a, 8'ha3);
    `CHK("wr nack", 1'b0, nack);
    `CHK("reg 5a", 8'ha3, regs0[8'h5a]);
    mCmd(1'b1, {tws_pkg::TGT_ADDR_HI, 1'b0}, 8'h5a, 8'h00);
    `CHK("rd data", 8'ha3, rdData);
    `CHK("rd nack", 1'b0, nack);
    mCmd(1'b0, {tws_pkg::TGT_ADDR_HI, 1'b1}, 8'h33, 8'h77);
    `CHK("sel0 nack", 1'b1, nack);
    `CHK("reg 33 kept", 8'h33, regs0[8'h33]);
    addrSel0 = 1'b1;
    mCmd(1'b0, {tws_pkg::TGT_ADDR_HI, 1'b1}, 8'h33, 8'h77);
    `CHK("sel1 nack", 1'b0, nack);
    `CHK("reg 33", 8'h77, regs0[8'h33]);
    mCmd(1'b1, dev0, 8'h33, 8'h00);
    `CHK("rd sel nack", 1'b1, nack);
    `CHK("rd kept", 8'ha3, rdData);
    $display("test master pair done");
  endtask
  task testBurstWrite;
    logic a;
    bStart();
    bByte({dev1, 1'b0}, a); `CHK("dev ack", 1'b1, a);
    bByte(8'hfe, a); `CHK("base ack", 1'b1, a);
    for (int i = 0; i < 4; i++) begin
      bByte(8'hc0 + 8'(i), a); `CHK("data ack", 1'b1, a);
    end
    bStop();
    for (int i = 0; i < 4; i++) `CHK("burst reg", 8'hc0 + 8'(i), regs1[8'hfe + 8'(i)]);
    $display("test burst write done");
  endtask
  task testBurstRead;
    logic a;
    logic [7:0] d;
    bStart(); bByte({dev1, 1'b0}, a); bByte(8'hfe, a);
    bStart();
    bByte({dev1, 1'b1}, a); `CHK("restart ack", 1'b1, a);
    for (int i = 0; i < 4; i++) begin
      bRead(i < 3, d); `CHK("burst rd", 8'hc0 + 8'(i), d);
    end
    // next byte at 02 starts with a zero, so a target still sending pulls low
    `CHK("nack release", 1'b0, bus1.tSdaOe);
    bStop();
    `CHK("read ptr", 8'h02, addr1);
    $display("test burst read done");
  endtask
  task testMismatch;
    logic a;
    bStart();
    bByte({tws_pkg::TGT_ADDR_HI, 1'b0, 1'b0}, a); `CHK("mis ack", 1'b0, a);
    bByte(8'h10, a); `CHK("mis base", 1'b0, a);
    bByte(8'h99, a); `CHK("mis data", 1'b0, a);
    bStop();
    `CHK("mis reg", 8'h10, regs1[8'h10]);
    `CHK("mis ptr", 8'h02, addr1);
    bByte({dev1, 1'b0}, a); `CHK("no start", 1'b0, a);
    bStop();
    bStart();
    bByte({dev1, 1'b0}, a); `CHK("recover", 1'b1, a);
    bStop();
    $display("test mismatch done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0; rst_b = 1'b0; cmdValid = 1'b0; cmdRead = 1'b0;
    cmdDev = 7'h00; cmdReg = 8'h00; cmdData = 8'h00;
    addrSel0 = 1'b0; addrSel1 = 1'b1;
    bus1.mSclOut = 1'b0; bus1.mSdaOut = 1'b0; bus1.mSclOe = 1'b0; bus1.mSdaOe = 1'b0;
    miscompares = 0; cmpCount = 0; cycles = 0;
    dev0 = {tws_pkg::TGT_ADDR_HI, 1'b0};
    dev1 = {tws_pkg::TGT_ADDR_HI, 1'b1};
    for (int i = 0; i < 256; i++) begin
      regs0[i] = 8'(i);
      regs1[i] = 8'(i);
    end
    repeat (12) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    testMasterPair();
    testBurstWrite();
    testBurstRead();
    testMismatch();
    summarize();
  end
endmodule
